// ==== bench/aqcd_cfg_model.sv ====
// Configuration writer standing in for the configuration state machine
`timescale 1ns/1ps
module aqcd_cfg_model (
  input wire clk,
  input wire [7:0] rdata,
  output logic wen = 1'b0,
  output logic [1:0] addr = 2'h0,
  output logic [7:0] wdata = 8'h00
);
  task wr(input [1:0] a, input [7:0] d);
    @(posedge clk);
    wen <= 1'b1;
    addr <= a;
    wdata <= (a == 2'h3) ? (d & 8'hba) : d;
    @(posedge clk);
    wen <= 1'b0;
    wdata <= ~d; // Scrambled when idle so no stale data is trusted
  endtask
  task rd(input [1:0] a, output [7:0] q);
    @(posedge clk);
    addr <= a;
    @(posedge clk);
    @(negedge clk);
    q = rdata;
  endtask
endmodule // aqcd_cfg_model

// ==== bench/aqcd_props.sv ====
// Port checks for the analog quad configuration decode
`timescale 1ns/1ps
module aqcd_props (
  input wire REF_CLK,
  input wire RST_N,
  input wire CFG_WEN,
  input wire [1:0] CFG_ADDR,
  input wire [7:0] CFG_WDATA,
  input wire [7:0] CFG_RDATA,
  input wire GATE_DRIVER_ON_INPUT,
  input wire [2:0] CPAD_RANGE,
  input wire [2:0] CPAD_ADC_SRC,
  input wire [2:0] VPAD_ADC_SRC,
  input wire GATE_LOW_DRIVE,
  input wire GATE_HIGH_DRIVE
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  sequence s_cw; CFG_WEN && CFG_ADDR == 2'h1; endsequence
  sequence s_gw; CFG_WEN && CFG_ADDR == 2'h2; endsequence
  sequence s_vw; CFG_WEN && CFG_ADDR == 2'h0; endsequence
  a_cpad_range: assert property (s_cw |=> CPAD_RANGE == $past(CFG_WDATA[2:0]))
    else $error("range");
  a_cpad_mux: assert property (s_cw |=> CPAD_ADC_SRC ==
    ($past(CFG_WDATA[4:3]) == 2'h3 ? 3'h0 : 3'h1 << $past(CFG_WDATA[4:3]))) else $error("mux");
  a_cpad_hold: assert property (!(CFG_WEN && CFG_ADDR == 2'h1) |=> $stable(CPAD_ADC_SRC))
    else $error("hold");
  a_vpad_mux: assert property (s_vw |=> VPAD_ADC_SRC ==
    ($past(CFG_WDATA[3]) ? 3'h2 : 3'h1)) else $error("voltage mux");
  a_vpad_src: assert property (VPAD_ADC_SRC == 3'h1 || VPAD_ADC_SRC == 3'h2)
    else $error("voltage source");
  a_rdata_reset: assert property ($rose(RST_N) |-> CFG_RDATA == 8'h00)
    else $error("reset");
  a_read_back: assert property (s_cw ##1 (!CFG_WEN && CFG_ADDR == 2'h1) |=>
    CFG_RDATA == $past(CFG_WDATA, 2)) else $error("readback");
  a_gate_off: assert property (!GATE_DRIVER_ON_INPUT |->
    !(GATE_LOW_DRIVE || GATE_HIGH_DRIVE)) else $error("gate off");
  a_gate_high: assert property (s_gw ##0 CFG_WDATA[7] ##1 GATE_DRIVER_ON_INPUT |->
    GATE_HIGH_DRIVE && !GATE_LOW_DRIVE) else $error("high");
  a_gate_low: assert property (s_gw ##0 !CFG_WDATA[7] ##1 GATE_DRIVER_ON_INPUT |->
    GATE_LOW_DRIVE && !GATE_HIGH_DRIVE) else $error("low");
endmodule // aqcd_props
bind aqcd_quad aqcd_props u_props (.REF_CLK(REF_CLK), .RST_N(RST_N), .CFG_WEN(CFG_WEN),
  .CFG_ADDR(CFG_ADDR), .CFG_WDATA(CFG_WDATA), .CFG_RDATA(CFG_RDATA),
  .GATE_DRIVER_ON_INPUT(GATE_DRIVER_ON_INPUT), .CPAD_RANGE(CPAD_RANGE),
  .CPAD_ADC_SRC(CPAD_ADC_SRC), .VPAD_ADC_SRC(VPAD_ADC_SRC),
  .GATE_LOW_DRIVE(GATE_LOW_DRIVE), .GATE_HIGH_DRIVE(GATE_HIGH_DRIVE));

// ==== bench/testbench.sv ====
// Self-checking bench for the analog quad configuration decode
`timescale 1ns/1ps
module testbench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic gen = 1'b0;
  logic [7:0] q;
  logic [7:0] e;
  logic [7:0] rb [4] = '{8'h60, 8'h60, 8'hcd, 8'h92};
  wire wen, vd, vn, vo, cm, cd, cn, co, td, tn, to, tm, gn, gl, gh;
  wire [1:0] ad, gc;
  wire [7:0] wd, rd;
  wire [2:0] vr, vs, cr, cs, tr, ts;
  int n_errors = 0;
  int tests_run = 0;
  always #5 clk = ~clk;
  aqcd_cfg_model cfg (.clk(clk), .rdata(rd), .wen(wen), .addr(ad), .wdata(wd));
  aqcd_quad dut (.REF_CLK(clk), .RST_N(rst_n), .CFG_WEN(wen), .CFG_ADDR(ad),
    .CFG_WDATA(wd), .CFG_RDATA(rd), .GATE_DRIVER_ON_INPUT(gen), .VPAD_RANGE(vr),
    .VPAD_ADC_SRC(vs), .VPAD_DIRECT_SW(vd), .VPAD_NEGATIVE(vn), .VPAD_OPAMP_ON(vo),
    .CURMON_SW(cm), .CPAD_RANGE(cr), .CPAD_ADC_SRC(cs), .CPAD_DIRECT_SW(cd),
    .CPAD_NEGATIVE(cn), .CPAD_OPAMP_ON(co), .TPAD_RANGE(tr), .TPAD_ADC_SRC(ts),
    .TPAD_DIRECT_SW(td), .TPAD_NEGATIVE(tn), .TPAD_OPAMP_ON(to), .TEMP_MON_ON(tm),
    .GATE_LOW_CURRENT(gc), .GATE_NEGATIVE(gn), .GATE_LOW_DRIVE(gl), .GATE_HIGH_DRIVE(gh));
  task end_sim;
    if (n_errors == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task chk(input [7:0] g, input [7:0] e);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %0t got %h exp %h", $time, g, e);
    end
  endtask
  task wc(input [1:0] a, input [7:0] d);
    cfg.wr(a, d);
    @(negedge clk);
  endtask
  task chk_dflt;
    chk({cs, vs, co, cm}, 8'h24);
    chk({cd, cn, vr, tr}, 8'h00);
    for (int i = 0; i < 4; i++) begin
      cfg.rd(i[1:0], q);
      chk(q, 8'h00);
    end
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk_dflt;
    for (int i = 0; i < 8; i++) begin
      wc(2'h1, {5'h10, i[2:0]});
      wc(2'h0, {5'h10, i[2:0]});
      chk({co, cd, cn, 2'h0, cr}, {5'h10, i[2:0]});
      chk({vo, vd, vn, 2'h0, vr}, {5'h10, i[2:0]});
    end
    for (int j = 0; j < 4; j++) begin
      wc(2'h1, {3'h0, j[1:0], 3'h0});
      wc(2'h0, {3'h0, j[1:0], 3'h0});
      e = {j == 3 ? 3'h0 : 3'h1 << j, j[0] ? 3'h2 : 3'h1, 1'b0, j[1]};
      chk({cs, vs, 1'b0, cm}, e);
    end
    wc(2'h1, 8'h60);
    wc(2'h0, 8'h60);
    wc(2'h3, 8'h60);
    chk({2'h0, td, tn, cd, cn, vd, vn}, 8'h2f);
    wc(2'h3, 8'hd7);
    chk({ts, tr, tn, to}, 8'h89);
    for (int k = 0; k < 32; k++) begin
      @(posedge clk) gen <= k[4];
      wc(2'h2, {k[3], k[2], 2'h0, k[1:0], 2'h1});
      e = {2'h0, k[1:0], k[2], k[4] & ~k[3], k[4] & k[3], 1'b1};
      chk({2'h0, gc, gn, gl, gh, tm}, e);
    end
    for (int i = 0; i < 4; i++) begin
      cfg.rd(i[1:0], q);
      chk(q, rb[i]);
    end
    // A reset in mid-run must bring every byte back to its default
    @(posedge clk) rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk_dflt;
    end_sim;
  end
  // The sequence needs well under a thousand cycles, so this leaves a wide margin
  initial begin
    #50000;
    n_errors++;
    end_sim;
  end
endmodule // testbench

// ==== common/aqcd_map.vh ====
// Field positions, byte indices and reset values of the analog quad configuration bytes
`ifndef AQCD_MAP_VH
`define AQCD_MAP_VH

// ----------------------------------------
// Byte indices within a quad (analog config mux address low bits)
// ----------------------------------------
`define AQCD_IDX_VOLTAGE 2'h0
`define AQCD_IDX_CURRENT 2'h1
`define AQCD_IDX_GATE 2'h2
`define AQCD_IDX_TEMP 2'h3

// ----------------------------------------
// Pad byte fields (voltage, current and temperature bytes)
// ----------------------------------------
`define AQCD_RANGE_LSB 0
`define AQCD_RANGE_MSB 2
`define AQCD_MUX_LO 3
`define AQCD_MUX_HI 4
`define AQCD_CURMON_SW 4
`define AQCD_DIRECT_SW 5
`define AQCD_POLARITY 6
`define AQCD_OPAMP_ON 7

// ----------------------------------------
// Gate driver byte fields
// ----------------------------------------
`define AQCD_TMON_ON 0
`define AQCD_LOWCUR_LSB 2
`define AQCD_LOWCUR_MSB 3
`define AQCD_GATE_POL 6
`define AQCD_GATE_HIGH 7

// ----------------------------------------
// Mux source codes and one-hot source outputs
// ----------------------------------------
`define AQCD_MUX_PRESCALER 2'h0
`define AQCD_MUX_DIRECT 2'h1
`define AQCD_MUX_MONITOR 2'h2
`define AQCD_MUX_INVALID 2'h3
`define AQCD_SRC_NONE 3'h0
`define AQCD_SRC_PRESCALER 3'h1
`define AQCD_SRC_DIRECT 3'h2
`define AQCD_SRC_MONITOR 3'h4

// ----------------------------------------
// Reset values: highest voltage range, prescaler, switches off, positive, op-amp down
// ----------------------------------------
`define AQCD_RST_PAD 8'h00
`define AQCD_RST_GATE 8'h00

`endif

// ==== logic/aqcd_cfg_byte.v ====
// One configuration byte held in flip-flops, written by the configuration mux
`timescale 1ns/1ps
module aqcd_cfg_byte #(
  parameter WIDTH = 8,
  parameter [WIDTH-1:0] RESET_VALUE = {WIDTH{1'b0}}
) (
  input wire clk,
  input wire rst_n,
  input wire wr_en,
  input wire [WIDTH-1:0] wr_data,
  output reg [WIDTH-1:0] value_q
);
  // Default holds until the configuration logic overwrites it
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      value_q <= RESET_VALUE;
    end else if (wr_en) begin
      value_q <= wr_data;
    end
  end
endmodule // aqcd_cfg_byte

// ==== logic/aqcd_pad_decode.v ====
// Decode of one pad byte (voltage, current or temperature) into front-end controls
`timescale 1ns/1ps
`include "aqcd_map.vh"
module aqcd_pad_decode #(
  parameter HAS_MUX_HI = 1
) (
  input wire [7:0] cfg,
  output wire [2:0] range_sel,
  output reg [2:0] adc_src,
  output wire direct_sw,
  output wire negative,
  output wire opamp_on
);
  wire [1:0] mux_code;

  // Prescaler range: code 0 is x0.15625, doubling per step up to x20.0
  assign range_sel = cfg[`AQCD_RANGE_MSB:`AQCD_RANGE_LSB];
  // Voltage pad has no upper select bit; its bit 4 is the current monitor switch
  assign mux_code = {(HAS_MUX_HI != 0) ? cfg[`AQCD_MUX_HI] : 1'b0, cfg[`AQCD_MUX_LO]};
  assign direct_sw = cfg[`AQCD_DIRECT_SW];
  assign negative = cfg[`AQCD_POLARITY];
  assign opamp_on = cfg[`AQCD_OPAMP_ON];

  // One-hot source select; invalid code connects nothing to avoid contention
  always @* begin
    case (mux_code)
      `AQCD_MUX_PRESCALER: adc_src = `AQCD_SRC_PRESCALER;
      `AQCD_MUX_DIRECT: adc_src = `AQCD_SRC_DIRECT;
      `AQCD_MUX_MONITOR: adc_src = `AQCD_SRC_MONITOR;
      default: adc_src = `AQCD_SRC_NONE;
    endcase
  end
endmodule // aqcd_pad_decode

// ==== logic/aqcd_quad.v ====
// Analog quad configuration: four bytes written over the configuration mux, decoded to controls
`timescale 1ns/1ps
`include "aqcd_map.vh"
module aqcd_quad (
  input wire REF_CLK,
  input wire RST_N,
  input wire CFG_WEN,
  input wire [1:0] CFG_ADDR,
  input wire [7:0] CFG_WDATA,
  output reg [7:0] CFG_RDATA,
  input wire GATE_DRIVER_ON_INPUT,
  output wire [2:0] VPAD_RANGE,
  output wire [2:0] VPAD_ADC_SRC,
  output wire VPAD_DIRECT_SW,
  output wire VPAD_NEGATIVE,
  output wire VPAD_OPAMP_ON,
  output wire CURMON_SW,
  output wire [2:0] CPAD_RANGE,
  output wire [2:0] CPAD_ADC_SRC,
  output wire CPAD_DIRECT_SW,
  output wire CPAD_NEGATIVE,
  output wire CPAD_OPAMP_ON,
  output wire [2:0] TPAD_RANGE,
  output wire [2:0] TPAD_ADC_SRC,
  output wire TPAD_DIRECT_SW,
  output wire TPAD_NEGATIVE,
  output wire TPAD_OPAMP_ON,
  output wire TEMP_MON_ON,
  output wire [1:0] GATE_LOW_CURRENT,
  output wire GATE_NEGATIVE,
  output wire GATE_LOW_DRIVE,
  output wire GATE_HIGH_DRIVE
);
  // ----------------------------------------
  // Configuration byte storage
  // ----------------------------------------
  wire [31:0] bytes_q;
  wire [3:0] byte_wen;
  reg [7:0] rdata_d;
  reg gate_low_drive;
  reg gate_high_drive;
  genvar gi;

  // One strobe per byte; a strobe held high only rewrites the same byte each edge
  assign byte_wen = CFG_WEN ? (4'h1 << CFG_ADDR) : 4'h0;

  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_byte
      aqcd_cfg_byte #(
        .WIDTH(8),
        .RESET_VALUE((gi == 2) ? `AQCD_RST_GATE : `AQCD_RST_PAD)
      ) u_byte (
        .clk(REF_CLK),
        .rst_n(RST_N),
        .wr_en(byte_wen[gi]),
        .wr_data(CFG_WDATA),
        .value_q(bytes_q[gi*8 +: 8])
      );
    end
  endgenerate

  wire [7:0] vbyte = bytes_q[7:0];
  wire [7:0] cbyte = bytes_q[15:8];
  wire [7:0] gbyte = bytes_q[23:16];
  wire [7:0] tbyte = bytes_q[31:24];

  // ----------------------------------------
  // Readback
  // ----------------------------------------
  always @* begin
    case (CFG_ADDR)
      `AQCD_IDX_VOLTAGE: rdata_d = vbyte;
      `AQCD_IDX_CURRENT: rdata_d = cbyte;
      `AQCD_IDX_GATE: rdata_d = gbyte;
      `AQCD_IDX_TEMP: rdata_d = tbyte;
      default: rdata_d = 8'h00;
    endcase
  end

  // Registered so the mux sees a stable byte the cycle after the address
  always @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      CFG_RDATA <= 8'h00;
    end else begin
      CFG_RDATA <= rdata_d;
    end
  end

  // ----------------------------------------
  // Pad decoders
  // ----------------------------------------
  aqcd_pad_decode #(.HAS_MUX_HI(0)) u_vpad (
    .cfg(vbyte),
    .range_sel(VPAD_RANGE),
    .adc_src(VPAD_ADC_SRC),
    .direct_sw(VPAD_DIRECT_SW),
    .negative(VPAD_NEGATIVE),
    .opamp_on(VPAD_OPAMP_ON)
  );
  aqcd_pad_decode #(.HAS_MUX_HI(1)) u_cpad (
    .cfg(cbyte),
    .range_sel(CPAD_RANGE),
    .adc_src(CPAD_ADC_SRC),
    .direct_sw(CPAD_DIRECT_SW),
    .negative(CPAD_NEGATIVE),
    .opamp_on(CPAD_OPAMP_ON)
  );
  // Range and polarity are passed through as written; out-of-range use is software's burden
  aqcd_pad_decode #(.HAS_MUX_HI(1)) u_tpad (
    .cfg(tbyte),
    .range_sel(TPAD_RANGE),
    .adc_src(TPAD_ADC_SRC),
    .direct_sw(TPAD_DIRECT_SW),
    .negative(TPAD_NEGATIVE),
    .opamp_on(TPAD_OPAMP_ON)
  );

  assign CURMON_SW = vbyte[`AQCD_CURMON_SW];

  // ----------------------------------------
  // Gate driver decode
  // ----------------------------------------
  assign TEMP_MON_ON = gbyte[`AQCD_TMON_ON];
  assign GATE_LOW_CURRENT = gbyte[`AQCD_LOWCUR_MSB:`AQCD_LOWCUR_LSB];
  assign GATE_NEGATIVE = gbyte[`AQCD_GATE_POL];

  // Both drive modes drop together with the enable, so the pad never sees a mixed mode
  always @* begin
    case ({GATE_DRIVER_ON_INPUT, gbyte[`AQCD_GATE_HIGH]})
      2'h2: begin
        gate_low_drive = 1'b1;
        gate_high_drive = 1'b0;
      end
      2'h3: begin
        gate_low_drive = 1'b0;
        gate_high_drive = 1'b1;
      end
      default: begin
        gate_low_drive = 1'b0;
        gate_high_drive = 1'b0;
      end
    endcase
  end

  assign GATE_LOW_DRIVE = gate_low_drive;
  assign GATE_HIGH_DRIVE = gate_high_drive;
endmodule // aqcd_quad
